// ### shared/arad_pkg.sv
// constants, register map and shift arithmetic for the result averager
package arad_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int SMP_W = 12;
  localparam int RES_W = 16;
  localparam int ACC_W = 22;
  localparam int CNT_W = 11;
  localparam int IRQ_W = 2;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_AVG_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_RESULT    = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h14;
  localparam logic [7:0] ADDR_FILL      = 8'h18;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_RES_LSB    = 1;
  localparam int AVG_SNUM_LSB   = 0;
  localparam int AVG_ADJ_LSB    = 4;
  localparam int IRQ_READY      = 0;
  localparam int IRQ_OVERRUN    = 1;
  localparam logic       CTL_ENABLE_RST = 1'h0;
  localparam logic [1:0] CTL_RES_RST    = 2'h0;
  localparam logic [3:0] AVG_SNUM_RST   = 4'h0;
  localparam logic [2:0] AVG_ADJ_RST    = 3'h0;

  // ****************************************
  // sample count codes and bus answers
  // ****************************************
  localparam logic [3:0] SNUM_NOAUTO = 4'h4;
  localparam logic [3:0] SNUM_MAX    = 4'hA;
  localparam logic [1:0] AXI_OKAY    = 2'h0;
  localparam logic [1:0] AXI_SLVERR  = 2'h2;

  function automatic logic [CNT_W-1:0] group_size(input logic [3:0] snum);
    if (snum <= SNUM_MAX) begin
      group_size = 11'h001 << snum;
    end else begin
      group_size = 11'h001;
    end
  endfunction

  function automatic logic [2:0] auto_shift(input logic [3:0] snum);
    if (snum > SNUM_NOAUTO && snum <= SNUM_MAX) begin
      auto_shift = 3'(snum - SNUM_NOAUTO);
    end else begin
      auto_shift = 3'h0;
    end
  endfunction

  function automatic logic [3:0] total_shift(input logic [3:0] snum, input logic [2:0] adj);
    if (snum > SNUM_MAX) begin
      total_shift = 4'h0;
    end else begin
      total_shift = {1'b0, auto_shift(snum)} + {1'b0, adj};
    end
  endfunction

endpackage

// ### src/arad_accum.sv
// sums a power-of-two group of conversion samples
`timescale 1ns/1ps
module arad_accum
  import arad_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // control
  input  wire logic             restart,
  input  wire logic [3:0]       sample_count_select,
  // samples
  input  wire logic             sample_valid,
  input  wire logic [SMP_W-1:0] sample_data,
  // group output
  output logic                  group_done,
  output logic [ACC_W-1:0]      group_sum,
  output logic [CNT_W-1:0]      fill_count
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [CNT_W-1:0] cnt;
    logic             done;
    logic [ACC_W-1:0] sum;
  } arad_acc_t;

  arad_acc_t st_r;
  arad_acc_t st_nxt;

  always_comb begin
    logic [ACC_W-1:0] acc_add;
    acc_add = st_r.acc + {{(ACC_W-SMP_W){1'b0}}, sample_data};
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (restart) begin
      st_nxt.acc = '0;
      st_nxt.cnt = '0;
    end else if (sample_valid) begin
      if (st_r.cnt + 11'h001 == group_size(sample_count_select)) begin // see RULE1
        st_nxt.sum  = acc_add;
        st_nxt.done = 1'b1; // see RULE4
        st_nxt.acc  = '0;
        st_nxt.cnt  = '0;
      end else begin
        st_nxt.acc = acc_add;
        st_nxt.cnt = st_r.cnt + 11'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign group_done = st_r.done;
  assign group_sum  = st_r.sum;
  assign fill_count = st_r.cnt;

endmodule

// ### src/arad_irq.sv
// sticky event flags, enable mask and the interrupt line
`timescale 1ns/1ps
module arad_irq
  import arad_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // events
  input  wire logic [IRQ_W-1:0] event_set,
  // software access
  input  wire logic             clear_wr,
  input  wire logic             enable_wr,
  input  wire logic [IRQ_W-1:0] wr_bits,
  // status
  output logic [IRQ_W-1:0]      status,
  output logic [IRQ_W-1:0]      enable,
  output logic                  irq
);

  typedef struct packed {
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] enable;
  } arad_irq_t;

  arad_irq_t st_r;
  arad_irq_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // set beats a clear landing in the same cycle
    if (clear_wr) begin
      st_nxt.status = st_r.status & ~wr_bits;
    end
    st_nxt.status = st_nxt.status | event_set; // see RULE5
    if (enable_wr) begin
      st_nxt.enable = wr_bits;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status = st_r.status;
  assign enable = st_r.enable;
  assign irq    = |(st_r.status & st_r.enable);

endmodule

// ### src/arad_top.sv
// result averager and decimator with its AXI4-Lite register slave
//
// Notes on behaviour
// RULE1: group of 1,2,4..1024 samples selected by sample count codes 0x0 to 0xA.
// RULE2: averaging divides the sum by count via auto shift plus adjust shift.
// RULE3: software sets resolution select to one before multi-sample work.
// RULE4: one output per completed group, rate reduced by the group size.
// RULE5: result ready flag rises only when a whole group is done and shifted.
// RULE6: group completion overwrites the result register with the new value.
// RULE7: 4^n samples shifted right by n give n extra bits, up to 16.
// RULE8: software uses code pairs 2/1, 4/2, 6/1, 8/0 for 13 to 16 bits.
// RULE9: total right shift equals automatic shift plus adjust field, auto 0..6.
// RULE10: groups above 16 samples auto shift 1 at 32 up to 6 at 1024.
// RULE11: codes 0xB to 0xF act as a single sample with no shifting.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module arad_top
  import arad_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // samples from the conversion core
  input  wire logic             sample_valid,
  input  wire logic [SMP_W-1:0] sample_data,
  // finished result
  output logic                  result_strobe,
  output logic [RES_W-1:0]      result_data,
  output logic                  irq,
  // axi4-lite write address
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [7:0]       s_axi_awaddr,
  // axi4-lite write data
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  // axi4-lite write response
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic [1:0]            s_axi_bresp,
  // axi4-lite read address
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [7:0]       s_axi_araddr,
  // axi4-lite read data
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic             aw_have;
    logic [7:0]       aw_addr;
    logic             w_have;
    logic [31:0]      w_data;
    logic             w_lane0;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             enable;
    logic [1:0]       res_sel;
    logic [3:0]       snum;
    logic [2:0]       adj;
    logic [RES_W-1:0] result;
    logic             res_strobe;
    logic [CNT_W-1:0] seen;
  } arad_state_t;

  arad_state_t st_r;
  arad_state_t st_nxt;

  logic             smp_take;
  logic             restart;
  logic             commit;
  logic             acc_done;
  logic [ACC_W-1:0] acc_sum;
  logic [CNT_W-1:0] fill_count;
  logic [RES_W-1:0] shifted;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [IRQ_W-1:0] irq_events;
  logic             clear_wr;
  logic             enable_wr;

  // ****************************************
  // sample path
  // ****************************************
  // samples arriving while disabled are dropped, not queued
  assign smp_take = sample_valid & st_r.enable;
  assign commit   = st_r.aw_have & st_r.w_have & ~st_r.bvalid;
  // a new group setting throws away the partial sum of the old one
  assign restart  = (commit & st_r.w_lane0
                     & (st_r.aw_addr == ADDR_AVG_CTRL || st_r.aw_addr == ADDR_CONTROL))
                    | ~st_r.enable;

  arad_accum u_accum (
    .clk                 (clk),
    .reset               (reset),
    .restart             (restart),
    .sample_count_select (st_r.snum),
    .sample_valid        (smp_take),
    .sample_data         (sample_data),
    .group_done          (acc_done),
    .group_sum           (acc_sum),
    .fill_count          (fill_count)
  );

  // the auto shift keeps the result within 16 bits even with the adjust code at zero
  assign shifted = RES_W'(acc_sum >> total_shift(st_r.snum, st_r.adj)); // see RULE2 see RULE9

  // ****************************************
  // interrupt flags
  // ****************************************
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_READY]   = acc_done; // see RULE5
    irq_events[IRQ_OVERRUN] = acc_done & irq_status[IRQ_READY];
  end

  assign clear_wr  = commit & st_r.w_lane0 & (st_r.aw_addr == ADDR_IRQ_CLEAR);
  assign enable_wr = commit & st_r.w_lane0 & (st_r.aw_addr == ADDR_IRQ_EN);

  arad_irq u_irq (
    .clk       (clk),
    .reset     (reset),
    .event_set (irq_events),
    .clear_wr  (clear_wr),
    .enable_wr (enable_wr),
    .wr_bits   (st_r.w_data[IRQ_W-1:0]),
    .status    (irq_status),
    .enable    (irq_enable),
    .irq       (irq)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.res_strobe = 1'b0;
    if (acc_done) begin
      st_nxt.result     = shifted; // see RULE6 see RULE7 see RULE10 see RULE11
      st_nxt.res_strobe = 1'b1;
    end
    if (restart) begin
      st_nxt.seen = '0;
    end else if (smp_take) begin
      if (st_r.seen + 11'h001 == group_size(st_r.snum)) begin
        st_nxt.seen = '0;
      end else begin
        st_nxt.seen = st_r.seen + 11'h001;
      end
    end
    // write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_have  = 1'b1;
      st_nxt.w_data  = s_axi_wdata;
      st_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (commit) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = AXI_OKAY;
      case (st_r.aw_addr)
        ADDR_CONTROL: begin
          if (st_r.w_lane0) begin
            st_nxt.enable  = st_r.w_data[CTL_ENABLE_BIT];
            st_nxt.res_sel = st_r.w_data[CTL_RES_LSB +: 2];
          end
        end
        ADDR_AVG_CTRL: begin
          if (st_r.w_lane0) begin
            st_nxt.snum = st_r.w_data[AVG_SNUM_LSB +: 4]; // see RULE1
            st_nxt.adj  = st_r.w_data[AVG_ADJ_LSB +: 3];
          end
        end
        ADDR_IRQ_CLEAR, ADDR_IRQ_EN, ADDR_RESULT, ADDR_IRQ_STAT, ADDR_FILL: begin
          st_nxt.bresp = AXI_OKAY;
        end
        default: begin
          st_nxt.bresp = AXI_SLVERR;
        end
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = '0;
      st_nxt.rresp  = AXI_OKAY;
      case (s_axi_araddr)
        ADDR_CONTROL: begin
          st_nxt.rdata[CTL_ENABLE_BIT]  = st_r.enable;
          st_nxt.rdata[CTL_RES_LSB +: 2] = st_r.res_sel;
        end
        ADDR_AVG_CTRL: begin
          st_nxt.rdata[AVG_SNUM_LSB +: 4] = st_r.snum;
          st_nxt.rdata[AVG_ADJ_LSB +: 3]  = st_r.adj;
        end
        ADDR_RESULT: begin
          st_nxt.rdata[RES_W-1:0] = st_r.result;
        end
        ADDR_IRQ_STAT: begin
          st_nxt.rdata[IRQ_W-1:0] = irq_status;
        end
        ADDR_IRQ_EN: begin
          st_nxt.rdata[IRQ_W-1:0] = irq_enable;
        end
        ADDR_FILL: begin
          st_nxt.rdata[CNT_W-1:0] = fill_count;
        end
        ADDR_IRQ_CLEAR: begin
          st_nxt.rdata = '0;
        end
        default: begin
          st_nxt.rresp = AXI_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r         <= '0;
      st_r.enable  <= CTL_ENABLE_RST;
      st_r.res_sel <= CTL_RES_RST;
      st_r.snum    <= AVG_SNUM_RST;
      st_r.adj     <= AVG_ADJ_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready = ~st_r.aw_have & ~st_r.bvalid;
  assign s_axi_wready  = ~st_r.w_have & ~st_r.bvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign result_strobe = st_r.res_strobe;
  assign result_data   = st_r.result;

  // ****************************************
  // checks
  // ****************************************
  logic [RES_W-1:0] avg_ref;
  logic [RES_W-1:0] dec16_ref;
  logic [RES_W-1:0] max_ref;
  logic [CNT_W-1:0] gsize;

  assign avg_ref   = RES_W'(acc_sum >> st_r.snum);
  assign dec16_ref = acc_sum[19:4];
  assign max_ref   = acc_sum[21:6];
  assign gsize     = group_size(st_r.snum);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_GROUP_DONE: assert property ( // see RULE1
    smp_take && !restart && st_r.seen + 11'h001 == gsize |=> acc_done)
    else $error("group did not complete at its size");

  AST_NO_EARLY_DONE: assert property ( // see RULE4
    !(smp_take && !restart && st_r.seen + 11'h001 == gsize) |=> !acc_done)
    else $error("group completed early");

  AST_AVERAGE: assert property ( // see RULE2
    acc_done && st_r.snum <= 4'h4 && {1'b0, st_r.adj} == st_r.snum
    |=> result_data == $past(avg_ref))
    else $error("average not sum divided by count");

  AST_FLAG_AT_GROUP: assert property ( // see RULE5
    $rose(irq_status[IRQ_READY]) |-> $past(acc_done))
    else $error("result ready rose without a finished group");

  AST_RESULT_WRITE: assert property ( // see RULE6
    acc_done |=> result_strobe && result_data == $past(shifted))
    else $error("result not replaced on group completion");

  AST_DECIMATE16: assert property ( // see RULE7
    acc_done && st_r.snum == 4'h8 && st_r.adj == 3'h0 |=> result_data == $past(dec16_ref))
    else $error("16-bit decimation wrong");

  AST_TOTAL_SHIFT: assert property ( // see RULE9
    acc_done && st_r.snum == 4'h6 && st_r.adj == 3'h1
    |=> result_data == RES_W'($past(acc_sum) >> 3))
    else $error("total shift not auto plus adjust");

  AST_AUTO_MAX: assert property ( // see RULE10
    acc_done && st_r.snum == 4'hA |=> result_data == $past(max_ref) >> $past(st_r.adj))
    else $error("auto shift at 1024 samples wrong");

  AST_RESERVED: assert property ( // see RULE11
    smp_take && !restart && st_r.snum > 4'hA |=> acc_done ##1 result_strobe)
    else $error("reserved code not a single sample");

  AST_STROBE_PULSE: assert property ( // see RULE4
    result_strobe |=> !result_strobe || $past(acc_done))
    else $error("result strobe stretched");

  COV_AVG1024: cover property (acc_done && st_r.snum == 4'hA);
  COV_DEC16:   cover property (acc_done && st_r.snum == 4'h8 && st_r.adj == 3'h0);
  COV_IRQ:     cover property ($rose(irq));
  COV_OVERRUN: cover property ($rose(irq_status[IRQ_OVERRUN]));

endmodule

// ### bench/arad_core_model.sv
// conversion core model feeding raw samples to the averager
`timescale 1ns/1ps
module arad_core_model
  import arad_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // command from the bench
  input  wire logic             go,
  input  wire logic [11:0]      count,
  input  wire logic [3:0]       gap,
  input  wire logic [11:0]      base,
  // sample stream
  output logic                  sample_valid,
  output logic [SMP_W-1:0]      sample_data,
  output logic                  idle
);
  logic [11:0] left_r;
  logic [11:0] next_r;
  logic [3:0]  wait_r;

  // *****
  // sample sequencer
  // *****
  always_ff @(posedge clk) begin
    if (reset) begin
      sample_valid <= 1'b0;
      sample_data  <= 12'hA5A;
      left_r       <= 12'h000;
      next_r       <= 12'h000;
      wait_r       <= 4'h0;
    end else begin
      sample_valid <= 1'b0;
      // outside a sample the data must not look valid
      if (sample_valid) begin
        sample_data <= ~sample_data;
      end
      if (go) begin
        left_r <= count;
        next_r <= base;
        wait_r <= 4'h0;
      end else if (left_r != 12'h000) begin
        if (wait_r != 4'h0) begin
          wait_r <= wait_r - 4'h1;
        end else begin
          sample_valid <= 1'b1;
          sample_data  <= next_r;
          next_r       <= next_r + 12'h001;
          left_r       <= left_r - 12'h001;
          wait_r       <= gap;
        end
      end
    end
  end

  assign idle = (left_r == 12'h000) && !go;
endmodule

// ### bench/arad_top_bench.sv
// self-checking bench for the result averager and decimator
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("Error at %0t ns: got %0h expected %0h", $time, (a), (e)); end end
module arad_top_bench
  import arad_pkg::*;
;
  localparam logic [11:0] BASE = 12'hE70;
  logic clk = 1'b0, reset = 1'b1, go = 1'b0, idle, sample_valid, irq;
  logic [11:0] count = 12'h000, base = BASE, sample_data;
  logic [3:0] gap = 4'h0, wstrb = 4'hF;
  logic result_strobe, awready, wready, bvalid, arready, rvalid;
  logic [15:0] result_data;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  int n_fail = 0, checked = 0, n_strobe = 0, cyc = 0;

  always #50 clk = ~clk;

  arad_top u_arad_top (.clk(clk), .reset(reset), .sample_valid(sample_valid),
    .sample_data(sample_data), .result_strobe(result_strobe), .result_data(result_data),
    .irq(irq), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  arad_core_model u_arad_core_model (.clk(clk), .reset(reset), .go(go), .count(count),
    .gap(gap), .base(base), .sample_valid(sample_valid), .sample_data(sample_data),
    .idle(idle));

  // *****
  // bus tasks
  // *****
  // ready is sampled at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid && bready; r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    `CHK(r, er)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready; tr = rvalid && rready; d = rdata; r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    `CHK(d, ed)
    `CHK(r, er)
  endtask

  task automatic feed(input int n, input logic [3:0] g);
    @(posedge clk);
    go <= 1'b1; count <= 12'(n); gap <= g;
    @(posedge clk);
    go <= 1'b0;
    while (!idle) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask

  // runs ng groups and checks the last group's value, strobes and flags
  task automatic run(input logic [3:0] c, input logic [2:0] adj, input int ng, input logic [3:0] g);
    int sz, s0, k, sh;
    logic [21:0] sum;
    logic [11:0] v;
    logic [15:0] er;
    sz = (c <= 4'hA) ? (1 << c) : 1;
    sh = (c > 4'hA) ? 0 : ((c > 4'h4) ? int'(c) - 4 : 0) + int'(adj);
    wr(ADDR_IRQ_CLEAR, 32'h3, AXI_OKAY);
    wr(ADDR_AVG_CTRL, {25'h0, adj, c}, AXI_OKAY);
    wr(ADDR_CONTROL, 32'h3, AXI_OKAY);
    s0 = n_strobe;
    feed(sz * ng, g);
    v = BASE + 12'(sz * (ng - 1));
    sum = 22'h0;
    for (k = 0; k < sz; k++) begin
      sum = sum + 22'(v);
      v = v + 12'h001;
    end
    er = 16'(sum >> sh);
    `CHK(n_strobe - s0, ng)
    `CHK(result_data, er)
    rd(ADDR_RESULT, {16'h0, er}, AXI_OKAY);
    rd(ADDR_IRQ_STAT, (ng > 1) ? 32'h3 : 32'h1, AXI_OKAY);
  endtask

  // *****
  // scenarios
  // *****
  task automatic t_reset;
    rd(ADDR_CONTROL, 32'h0, AXI_OKAY);
    rd(ADDR_AVG_CTRL, 32'h0, AXI_OKAY);
    rd(ADDR_IRQ_STAT, 32'h0, AXI_OKAY);
    rd(ADDR_IRQ_EN, 32'h0, AXI_OKAY);
    rd(8'h1C, 32'h0, AXI_SLVERR);
    wr(8'h1C, 32'h1, AXI_SLVERR);
    wr(ADDR_RESULT, 32'hFFFF, AXI_OKAY);
    rd(ADDR_RESULT, 32'h0, AXI_OKAY);
  endtask

  task automatic t_average;
    int c;
    for (c = 0; c <= 10; c++) begin
      run(4'(c), (c > 4) ? 3'h4 : 3'(c), 2, 4'h0);
    end
  endtask

  task automatic t_oversample;
    run(4'h2, 3'h1, 1, 4'h1);
    run(4'h4, 3'h2, 1, 4'h2);
    run(4'h6, 3'h1, 1, 4'h1);
    run(4'h8, 3'h0, 1, 4'h0);
  endtask

  task automatic t_reserved;
    int c;
    for (c = 11; c <= 15; c++) begin
      run(4'(c), 3'h3, 2, 4'h1);
    end
  endtask

  // a partial group must stay silent and keep its fill count
  task automatic t_partial;
    int s0;
    wr(ADDR_AVG_CTRL, 32'h3, AXI_OKAY);
    s0 = n_strobe;
    feed(5, 4'h0);
    `CHK(n_strobe - s0, 0)
    rd(ADDR_FILL, 32'h5, AXI_OKAY);
    // a write without byte lane 0 must neither change the setting nor restart the group
    wstrb <= 4'hE;
    wr(ADDR_AVG_CTRL, 32'h0, AXI_OKAY);
    wstrb <= 4'hF;
    rd(ADDR_AVG_CTRL, 32'h3, AXI_OKAY);
    rd(ADDR_FILL, 32'h5, AXI_OKAY);
    rd(ADDR_CONTROL, 32'h3, AXI_OKAY);
  endtask

  task automatic t_irq;
    wr(ADDR_IRQ_EN, 32'h1, AXI_OKAY);
    run(4'h1, 3'h1, 1, 4'h0);
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_CLEAR, 32'h1, AXI_OKAY);
    `CHK(irq, 1'b0)
    rd(ADDR_IRQ_STAT, 32'h0, AXI_OKAY);
    wr(ADDR_IRQ_EN, 32'h0, AXI_OKAY);
    run(4'h0, 3'h0, 1, 4'h0);
    `CHK(irq, 1'b0)
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // *****
  // monitors and main sequence
  // *****
  always @(posedge clk) begin
    if (result_strobe === 1'b1) n_strobe <= n_strobe + 1;
  end

  // the whole run needs well under ten thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_average();
    t_oversample();
    t_reserved();
    t_partial();
    t_irq();
    report_and_stop();
  end
endmodule
